// file: dv/clkout_monitor.sv
// port checker of the clock channel output logic
`timescale 1ns/1ps
`default_nettype none
module clkout_monitor
    import clkout_pkg::*;
(
    // clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        NRST_I,
    // apb
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    input  wire logic [3:0]  PSTRB_I,
    input  wire logic [31:0] PRDATA_O,
    input  wire logic        PREADY_O,
    input  wire logic        PSLVERR_O,
    // sysref sequencer and output stages
    input  wire logic        SYSREF_START_I,
    input  wire logic        SYSREF_DONE_I,
    input  wire logic        SYSREF_BUSY_O,
    input  wire logic [19:0] CLK_STATE_O,
    input  wire logic [19:0] CLK_AMP_O,
    input  wire logic [15:0] REF_STATE_O,
    input  wire logic [15:0] REF_AMP_O,
    input  wire logic [7:0]  REF_DIV_SEL_O,
    input  wire logic [7:0]  REF_DELAY_SEL_O
);
    // ********************
    // write taken at this edge; outputs follow two samples later
    // ********************
    wire logic wr    = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
    wire logic sw_go = wr && PADDR_I == ADDR_SYSREF && PSTRB_I[0] && PWDATA_I[SR_START_BIT];

    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!NRST_I);

    AST_READY_ONE: assert property (PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
        else $error("ready not one cycle");
    AST_DIV_SEL: assert property (wr && PADDR_I == ADDR_REF_CFG && PSTRB_I[0]
        |-> ##2 REF_DIV_SEL_O == $past(PWDATA_I[7:0], 2)) else $error("divider select not taken");
    AST_DELAY_SEL: assert property (REF_DELAY_SEL_O == REF_DIV_SEL_O)
        else $error("delay select differs");
    AST_CLK_AMP: assert property (wr && PADDR_I == ADDR_CLK_AMP && PSTRB_I == 4'hF
        |-> ##2 CLK_AMP_O == $past(PWDATA_I[19:0], 2)) else $error("clock amplitude not passed");
    AST_CLK_OFF: assert property (wr && PADDR_I == ADDR_CLK_PWR && PSTRB_I[0] && PWDATA_I[0]
        |-> ##2 CLK_STATE_O[1:0] == OUT_OFF) else $error("powered off clock active");
    AST_CHAN_A_OFF: assert property (wr && PADDR_I == ADDR_CLK_PWR && PSTRB_I[2] && PWDATA_I[16]
        |-> ##2 REF_STATE_O[5:0] == 6'h0) else $error("channel A reference not off");
    AST_CHAN_E_OFF: assert property (wr && PADDR_I == ADDR_CLK_PWR && PSTRB_I[2] && PWDATA_I[20]
        |-> ##2 CLK_STATE_O[19:16] == 4'h0) else $error("channel E power-off ignored");
    AST_NO_CLK_BIAS: assert property ((CLK_STATE_O & (CLK_STATE_O >> 1) & 20'h55555) == 20'h0)
        else $error("clock output in line bias");
    AST_START: assert property ($rose(SYSREF_BUSY_O)
        |-> $past(SYSREF_START_I, 2) || $past(sw_go, 3)) else $error("busy without a start");
    AST_DONE: assert property (SYSREF_BUSY_O && SYSREF_DONE_I && !SYSREF_START_I
        |-> ##3 !SYSREF_BUSY_O) else $error("event not closed after done");

    // main scenarios reached
    cover property ($rose(SYSREF_BUSY_O));
    cover property (PSLVERR_O);
    cover property (sw_go);
endmodule

bind clock_channel_output_logic clkout_monitor u_mon (.CLOCK_I, .NRST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
    .PWDATA_I, .PSTRB_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .SYSREF_START_I, .SYSREF_DONE_I, .SYSREF_BUSY_O,
    .CLK_STATE_O, .CLK_AMP_O, .REF_STATE_O, .REF_AMP_O, .REF_DIV_SEL_O, .REF_DELAY_SEL_O);
`default_nettype wire

// file: dv/tb.sv
// self-checking testbench of the clock channel output logic
`timescale 1ns/1ps
`default_nettype none
module tb;
    import clkout_pkg::*;

    // expected answer of one bus transfer
    typedef struct packed
    {
        logic [31:0] data;
        logic [31:0] mask;
        logic        err;
    } note_t;

    logic        clk, nrst, psel, penable, pwrite, sr_start, sr_done, act;
    logic        pready, pslverr, busy;
    logic [7:0]  paddr, div_sel, dly_sel;
    logic [31:0] pwdata, prdata, v;
    logic [3:0]  pstrb;
    logic [19:0] clk_state, clk_amp;
    logic [15:0] ref_state, ref_amp, seed;
    logic [31:0] sh[8];
    logic [31:0] msk[8] = '{MASK_CLK_PWR, MASK_CLK_EN, MASK_CLK_AMP, MASK_REF_CFG, MASK_REF_EN, MASK_REF_AMP,
        32'h0, 32'h0};
    note_t       notes[$];
    int          failures, n_tests, cycles;

    clock_channel_output_logic dut (.CLOCK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .SYSREF_START_I(sr_start), .SYSREF_DONE_I(sr_done),
        .SYSREF_BUSY_O(busy), .CLK_STATE_O(clk_state), .CLK_AMP_O(clk_amp), .REF_STATE_O(ref_state),
        .REF_AMP_O(ref_amp), .REF_DIV_SEL_O(div_sel), .REF_DELAY_SEL_O(dly_sel));

    // ********************
    // clock, hang guard and answer watcher
    // ********************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // a hang ends the run here
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            print_verdict();
        end
    end

    // each completed transfer retires the oldest note
    always @(posedge clk)
        if (psel && penable && pready === 1'b1)
        begin
            compare("pslverr", {31'h0, notes[0].err}, {31'h0, pslverr});
            compare("prdata", notes[0].data & notes[0].mask, prdata & notes[0].mask);
            void'(notes.pop_front());
        end

    // ********************
    // tasks
    // ********************
    task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // one transfer; held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       input note_t n);
        notes.push_back(n);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, s};
        @(posedge clk);
        penable <= 1'b1;
        while (pready !== 1'b1)
            @(posedge clk);
        {psel, penable} <= 2'b00;
    endtask

    // shadow follows only the strobed, writable bits
    task automatic wreg(input int i, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] bm;
        bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & msk[i];
        sh[i] = (sh[i] & ~bm) | (d & bm);
        apb(1'b1, 8'(i * 4), d, s, '{32'h0, 32'h0, 1'b0});
    endtask

    task automatic rreg(input int i);
        logic w;
        w = 1'b0;
        for (int r = 0; r < NUM_REF; r++)
            w = w | (sh[3][r] && sh[5][2*r+:2] != AMP_SYSREF);
        apb(1'b0, 8'(i * 4), 32'h0, 4'hF, '{(i == 7) ? {30'h0, w, act} : sh[i],
            (i == 7) ? 32'hFFFF_00FF : 32'hFFFF_FFFF, 1'b0});
    endtask

    function automatic logic [1:0] clk_exp(input int y);
        if (sh[0][y] || sh[0][CHAN_PD_LSB + CLK_CHAN_MAP[3*y+:3]])
            return OUT_OFF;
        return sh[1][y] ? OUT_ON : OUT_LOW;
    endfunction

    function automatic logic [1:0] ref_exp(input int r);
        if (sh[0][CHAN_PD_LSB + REF_CHAN_MAP[3*r+:3]])
            return OUT_OFF;
        if (!sh[3][r])
            return sh[3][REF_PD_LSB+r] ? OUT_OFF : (sh[4][r] ? OUT_ON : OUT_LOW);
        if (sh[3][REF_BIAS_LSB+r])
            return OUT_BIAS;
        return !act ? OUT_OFF : (sh[4][r] ? OUT_ON : OUT_LOW);
    endfunction

    task automatic check_outputs();
        logic [19:0] ec;
        logic [15:0] er;
        for (int y = 0; y < NUM_CLK; y++)
            ec[2*y+:2] = clk_exp(y);
        for (int r = 0; r < NUM_REF; r++)
            er[2*r+:2] = ref_exp(r);
        compare("clk_state", {12'h0, ec}, {12'h0, clk_state});
        compare("ref_state", {16'h0, er}, {16'h0, ref_state});
        compare("clk_amp", {12'h0, sh[2][19:0]}, {12'h0, clk_amp});
        compare("ref_amp", {16'h0, sh[5][15:0]}, {16'h0, ref_amp});
        compare("div_sel", {24'h0, sh[3][7:0]}, {24'h0, div_sel});
        compare("dly_sel", {24'h0, sh[3][7:0]}, {24'h0, dly_sel});
        compare("busy", {31'h0, act}, {31'h0, busy});
    endtask

    // ********************
    // main sequence
    // ********************
    initial
    begin
        {nrst, psel, penable, pwrite, paddr, pwdata, pstrb, sr_start, sr_done, act} = '0;
        sh = '{RST_CLK_PWR, RST_CLK_EN, RST_CLK_AMP, RST_REF_CFG, RST_REF_EN, RST_REF_AMP, 32'h0, 32'h0};
        seed = 16'h94E7; // 38119
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1 check_outputs();
        for (int i = 0; i < 8; i++)
            rreg(i);
        $display("test reset done");
        apb(1'b0, 8'h20, 32'h0, 4'hF, '{32'h0, 32'hFFFF_FFFF, 1'b1});
        wreg(7, 32'hFFFF_FFFF, 4'hF);
        rreg(7);
        wreg(2, 32'h0, 4'h2);
        $display("test refusal and strobe done");
        // random settings; bias only where the sysref function is chosen
        repeat (8)
        begin
            for (int i = 0; i < 6; i++)
            begin
                repeat (2) seed = lfsr(seed);
                v = {seed, seed[7:0], seed[15:8]} ^ {16'h0, seed};
                if (i == 3)
                    v[23:16] = v[23:16] & v[7:0];
                wreg(i, v, 4'hF);
            end
            @(posedge clk);
            #1 check_outputs();
            for (int i = 0; i < 8; i++)
                rreg(i);
        end
        $display("test random settings done");
        wreg(0, 32'h0, 4'hF);
        wreg(3, 32'h0040_00F3, 4'hF);
        wreg(4, 32'h0000_005A, 4'hF);
        wreg(5, 32'h0000_5555, 4'hF);
        @(posedge clk);
        #1 check_outputs();
        @(posedge clk);
        sr_start <= 1'b1;
        @(posedge clk);
        sr_start <= 1'b0;
        act = 1'b1;
        repeat (2) @(posedge clk);
        #1 check_outputs();
        rreg(7);
        @(posedge clk);
        sr_done <= 1'b1;
        @(posedge clk);
        sr_done <= 1'b0;
        act = 1'b0;
        repeat (2) @(posedge clk);
        #1 check_outputs();
        $display("test pin event done");
        wreg(5, 32'h0000_5557, 4'hF);
        rreg(7);
        wreg(6, 32'h0000_0001, 4'h2);
        repeat (3) @(posedge clk);
        #1 check_outputs();
        wreg(6, 32'h0000_0001, 4'hF);
        act = 1'b1;
        repeat (3) @(posedge clk);
        #1 check_outputs();
        wreg(6, 32'h0000_0002, 4'hF);
        act = 1'b0;
        repeat (3) @(posedge clk);
        #1 check_outputs();
        $display("test software event done");
        print_verdict();
    end
endmodule
`default_nettype wire

// file: pkg/clkout_pkg.sv
// constants, register map and types of the clock channel output logic
package clkout_pkg;

    // output population
    localparam int NUM_CLK  = 10;
    localparam int NUM_REF  = 8;
    localparam int NUM_CHAN = 5;

    // register byte offsets
    localparam logic [7:0] ADDR_CLK_PWR = 8'h00;
    localparam logic [7:0] ADDR_CLK_EN  = 8'h04;
    localparam logic [7:0] ADDR_CLK_AMP = 8'h08;
    localparam logic [7:0] ADDR_REF_CFG = 8'h0C;
    localparam logic [7:0] ADDR_REF_EN  = 8'h10;
    localparam logic [7:0] ADDR_REF_AMP = 8'h14;
    localparam logic [7:0] ADDR_SYSREF  = 8'h18;
    localparam logic [7:0] ADDR_STATUS  = 8'h1C;

    // field positions
    localparam int CHAN_PD_LSB   = 16;
    localparam int REF_PD_LSB    = 8;
    localparam int REF_BIAS_LSB  = 16;
    localparam int SR_START_BIT  = 0;
    localparam int SR_STOP_BIT   = 1;
    localparam int ST_ACTIVE_BIT = 0;
    localparam int ST_AMPWARN_BIT = 1;
    localparam int ST_LIVE_LSB   = 8;

    // writable bits of each register
    localparam logic [31:0] MASK_CLK_PWR = 32'h001F_03FF;
    localparam logic [31:0] MASK_CLK_EN  = 32'h0000_03FF;
    localparam logic [31:0] MASK_CLK_AMP = 32'h000F_FFFF;
    localparam logic [31:0] MASK_REF_CFG = 32'h00FF_FFFF;
    localparam logic [31:0] MASK_REF_EN  = 32'h0000_00FF;
    localparam logic [31:0] MASK_REF_AMP = 32'h0000_FFFF;

    // reset values: all powered, disabled, 500 mV code, clock function
    localparam logic [31:0] RST_CLK_PWR = 32'h0000_0000;
    localparam logic [31:0] RST_CLK_EN  = 32'h0000_0000;
    localparam logic [31:0] RST_CLK_AMP = 32'h0005_5555;
    localparam logic [31:0] RST_REF_CFG = 32'h0000_0000;
    localparam logic [31:0] RST_REF_EN  = 32'h0000_0000;
    localparam logic [31:0] RST_REF_AMP = 32'h0000_5555;

    // amplitude code expected on outputs in sysref function
    localparam logic [1:0] AMP_SYSREF = 2'h1;

    // channel of each output, 0=A .. 4=E, output 0 in the low bits
    localparam logic [29:0] CLK_CHAN_MAP = {3'h4, 3'h4, 3'h3, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0};
    localparam logic [23:0] REF_CHAN_MAP = {3'h3, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0};

    // driver state handed to each analog output stage
    typedef enum logic [1:0] {
        OUT_OFF  = 2'b00,
        OUT_LOW  = 2'b01,
        OUT_ON   = 2'b10,
        OUT_BIAS = 2'b11
    } out_state_t;

    // sysref hand-over state
    typedef enum logic [1:0] {
        SR_IDLE   = 2'b00,
        SR_ACTIVE = 2'b01
    } sysref_state_t;

endpackage

// file: pkg/sysref_ctl_if.sv
// control link between the output logic and the sysref hand-over machine
`timescale 1ns/1ps
`default_nettype none
interface sysref_ctl_if;
    import clkout_pkg::*;
    logic          start;
    logic          stop;
    logic          done;
    logic          active;
    sysref_state_t state;

    modport ctrl (output start, output stop, output done, input active, input state);
    modport fsm  (input start, input stop, input done, output active, output state);
endinterface
`default_nettype wire

// file: src/clock_channel_output_logic.sv
// per-channel output steering, power, enable and amplitude control
//
// Summary of operation
// R1: each reference output picks sysref or clock
// R2: channels A-D hold clock and reference outputs
// R3: channel E has two clocks, no references
// R4: sysref references switched by the event logic
// R5: clock-mode references use their own settings
// R6: divider: channel in clock, global in sysref
// R7: delay: channel in clock, own in sysref
// R8: power-off per output, per channel for sysref
// R9: enable per clock and reference output
// R10: two-bit amplitude code per output
// R11: sysref output state from internal state machine
// R12: software sets 500 mV code before events
// R13: bias bit holds idle line at midpoint
// R14: enable low drives low; power-off wins
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module clock_channel_output_logic
    import clkout_pkg::*;
(
    // clock and reset
    input  wire logic                  CLOCK_I,
    input  wire logic                  NRST_I,
    // apb slave
    input  wire logic                  PSEL_I,
    input  wire logic                  PENABLE_I,
    input  wire logic                  PWRITE_I,
    input  wire logic [7:0]            PADDR_I,
    input  wire logic [31:0]           PWDATA_I,
    input  wire logic [3:0]            PSTRB_I,
    output logic      [31:0]           PRDATA_O,
    output logic                       PREADY_O,
    output logic                       PSLVERR_O,
    // sysref sequencer
    input  wire logic                  SYSREF_START_I,
    input  wire logic                  SYSREF_DONE_I,
    output logic                       SYSREF_BUSY_O,
    // clock output stages
    output logic      [2*NUM_CLK-1:0]  CLK_STATE_O,
    output logic      [2*NUM_CLK-1:0]  CLK_AMP_O,
    // reference output stages
    output logic      [2*NUM_REF-1:0]  REF_STATE_O,
    output logic      [2*NUM_REF-1:0]  REF_AMP_O,
    output logic      [NUM_REF-1:0]    REF_DIV_SEL_O,
    output logic      [NUM_REF-1:0]    REF_DELAY_SEL_O
);

    // ******************************************
    // declarations
    // ******************************************
    logic [31:0]          clk_pwr_reg;
    logic [31:0]          clk_en_reg;
    logic [31:0]          clk_amp_reg;
    logic [31:0]          ref_cfg_reg;
    logic [31:0]          ref_en_reg;
    logic [31:0]          ref_amp_reg;
    logic [31:0]          status_word;
    logic [31:0]          next_rdata;
    logic                 next_slverr;
    logic                 wr_access;
    logic                 sw_start;
    logic                 sw_stop;
    logic                 amp_warn;
    logic [NUM_REF-1:0]   ref_live;
    logic [NUM_CLK-1:0]   clk_power_off;
    logic [NUM_CLK-1:0]   clk_enable;
    logic [NUM_CHAN-1:0]  chan_power_off;
    logic [NUM_REF-1:0]   output_function_select;
    logic [NUM_REF-1:0]   ref_power_off;
    logic [NUM_REF-1:0]   idle_line_bias;
    logic [NUM_REF-1:0]   ref_enable;

    sysref_ctl_if ctl ();

    // byte-lane merge limited to the writable bits
    function automatic logic [31:0] merge_word(input logic [31:0] old_word,
                                               input logic [31:0] new_word,
                                               input logic [3:0]  strb,
                                               input logic [31:0] mask);
        logic [31:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old_word & ~(lanes & mask)) | (new_word & lanes & mask);
    endfunction

    // ******************************************
    // field views
    // ******************************************
    assign clk_power_off          = clk_pwr_reg[NUM_CLK-1:0];
    assign chan_power_off         = clk_pwr_reg[CHAN_PD_LSB +: NUM_CHAN];
    assign clk_enable             = clk_en_reg[NUM_CLK-1:0];
    assign output_function_select = ref_cfg_reg[NUM_REF-1:0];        // [R1]
    assign ref_power_off          = ref_cfg_reg[REF_PD_LSB +: NUM_REF];
    assign idle_line_bias         = ref_cfg_reg[REF_BIAS_LSB +: NUM_REF];
    assign ref_enable             = ref_en_reg[NUM_REF-1:0];

    // ******************************************
    // apb slave
    // ******************************************
    // writes land at the access edge where pready is seen high
    assign wr_access = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;

    // configuration registers
    always_ff @(posedge CLOCK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            clk_pwr_reg <= RST_CLK_PWR;
            clk_en_reg  <= RST_CLK_EN;
            clk_amp_reg <= RST_CLK_AMP;
            ref_cfg_reg <= RST_REF_CFG;
            ref_en_reg  <= RST_REF_EN;
            ref_amp_reg <= RST_REF_AMP;
        end
        else if (wr_access)
        begin
            if (PADDR_I == ADDR_CLK_PWR)
                clk_pwr_reg <= merge_word(clk_pwr_reg, PWDATA_I, PSTRB_I, MASK_CLK_PWR);  // [R8]
            else if (PADDR_I == ADDR_CLK_EN)
                clk_en_reg <= merge_word(clk_en_reg, PWDATA_I, PSTRB_I, MASK_CLK_EN);     // [R9]
            else if (PADDR_I == ADDR_CLK_AMP)
                clk_amp_reg <= merge_word(clk_amp_reg, PWDATA_I, PSTRB_I, MASK_CLK_AMP);  // [R10]
            else if (PADDR_I == ADDR_REF_CFG)
                ref_cfg_reg <= merge_word(ref_cfg_reg, PWDATA_I, PSTRB_I, MASK_REF_CFG);  // [R1]
            else if (PADDR_I == ADDR_REF_EN)
                ref_en_reg <= merge_word(ref_en_reg, PWDATA_I, PSTRB_I, MASK_REF_EN);     // [R9]
            else if (PADDR_I == ADDR_REF_AMP)
                ref_amp_reg <= merge_word(ref_amp_reg, PWDATA_I, PSTRB_I, MASK_REF_AMP);  // [R10]
        end
    end

    // software sysref commands, one-cycle pulses, low byte lane only
    always_ff @(posedge CLOCK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            sw_start <= 1'b0;
            sw_stop  <= 1'b0;
        end
        else
        begin
            sw_start <= wr_access && (PADDR_I == ADDR_SYSREF) && PSTRB_I[0] && PWDATA_I[SR_START_BIT];
            sw_stop  <= wr_access && (PADDR_I == ADDR_SYSREF) && PSTRB_I[0] && PWDATA_I[SR_STOP_BIT];
        end
    end

    // status: hand-over state, amplitude check and live references
    always_comb
    begin
        status_word                 = 32'h0000_0000;
        status_word[ST_ACTIVE_BIT]  = ctl.active;
        status_word[ST_AMPWARN_BIT] = amp_warn;
        status_word[ST_LIVE_LSB +: NUM_REF] = ref_live;
    end

    // read decode; unmapped addresses answer with pslverr and zero data
    always_comb
    begin
        next_rdata  = 32'h0000_0000;
        next_slverr = 1'b0;
        if (PADDR_I == ADDR_CLK_PWR)
            next_rdata = clk_pwr_reg;
        else if (PADDR_I == ADDR_CLK_EN)
            next_rdata = clk_en_reg;
        else if (PADDR_I == ADDR_CLK_AMP)
            next_rdata = clk_amp_reg;
        else if (PADDR_I == ADDR_REF_CFG)
            next_rdata = ref_cfg_reg;
        else if (PADDR_I == ADDR_REF_EN)
            next_rdata = ref_en_reg;
        else if (PADDR_I == ADDR_REF_AMP)
            next_rdata = ref_amp_reg;
        else if (PADDR_I == ADDR_SYSREF)
            next_rdata = 32'h0000_0000;     // command bits read back as zero
        else if (PADDR_I == ADDR_STATUS)
            next_rdata = status_word;
        else
            next_slverr = 1'b1;
    end

    // answer prepared in the setup cycle so the access phase has no wait
    always_ff @(posedge CLOCK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            PRDATA_O  <= 32'h0000_0000;
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
        end
        else
        begin
            PREADY_O <= PSEL_I && !PENABLE_I;
            if (PSEL_I && !PENABLE_I)
            begin
                PRDATA_O  <= PWRITE_I ? 32'h0000_0000 : next_rdata;
                PSLVERR_O <= next_slverr;
            end
            else
            begin
                PRDATA_O  <= 32'h0000_0000;
                PSLVERR_O <= 1'b0;
            end
        end
    end

    // ******************************************
    // sysref hand-over
    // ******************************************
    // either the sequencer or software may open an event
    assign ctl.start = sw_start || SYSREF_START_I;                    // [R4]
    assign ctl.stop  = sw_stop;
    assign ctl.done  = SYSREF_DONE_I;

    sysref_handover u_handover (
        .CLOCK_I (CLOCK_I),
        .NRST_I  (NRST_I),
        .ctl     (ctl)
    );                                                                // [R11]

    // busy flag mirrors the hand-over machine
    always_ff @(posedge CLOCK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            SYSREF_BUSY_O <= 1'b0;
        else
            SYSREF_BUSY_O <= (ctl.state == SR_ACTIVE);
    end

    // ******************************************
    // clock outputs
    // ******************************************
    // channel E sits in this loop only; it has no reference stage
    for (genvar y = 0; y < NUM_CLK; y++)
    begin : g_clk
        logic [2:0] chan;
        assign chan = CLK_CHAN_MAP[3*y +: 3];                         // [R2] [R3]

        // power-off first, then enable; disabled stage drives low
        always_ff @(posedge CLOCK_I or negedge NRST_I)
        begin
            if (!NRST_I)
                CLK_STATE_O[2*y +: 2] <= OUT_OFF;
            else if (clk_power_off[y] || chan_power_off[chan])
                CLK_STATE_O[2*y +: 2] <= OUT_OFF;                     // [R8] [R14]
            else if (!clk_enable[y])
                CLK_STATE_O[2*y +: 2] <= OUT_LOW;                     // [R14]
            else
                CLK_STATE_O[2*y +: 2] <= OUT_ON;                      // [R9]
        end

        // amplitude code passed straight to the driver
        always_ff @(posedge CLOCK_I or negedge NRST_I)
        begin
            if (!NRST_I)
                CLK_AMP_O[2*y +: 2] <= RST_CLK_AMP[2*y +: 2];
            else
                CLK_AMP_O[2*y +: 2] <= clk_amp_reg[2*y +: 2];         // [R10]
        end
    end

    // ******************************************
    // reference outputs
    // ******************************************
    for (genvar r = 0; r < NUM_REF; r++)
    begin : g_ref
        logic [2:0] chan;
        logic       sysref_fn;
        assign chan      = REF_CHAN_MAP[3*r +: 3];                    // [R2]
        assign sysref_fn = output_function_select[r];

        // clock function follows own bits; sysref function is owned by the event
        always_ff @(posedge CLOCK_I or negedge NRST_I)
        begin
            if (!NRST_I)
                REF_STATE_O[2*r +: 2] <= OUT_OFF;
            else if (!sysref_fn)
            begin
                if (ref_power_off[r] || chan_power_off[chan])
                    REF_STATE_O[2*r +: 2] <= OUT_OFF;                 // [R5] [R8]
                else if (!ref_enable[r])
                    REF_STATE_O[2*r +: 2] <= OUT_LOW;                 // [R5] [R14]
                else
                    REF_STATE_O[2*r +: 2] <= OUT_ON;                  // [R5]
            end
            else if (chan_power_off[chan])
                REF_STATE_O[2*r +: 2] <= OUT_OFF;                     // [R8]
            else if (idle_line_bias[r])
                REF_STATE_O[2*r +: 2] <= OUT_BIAS;                    // [R13]
            else if (ctl.active)
                REF_STATE_O[2*r +: 2] <= ref_enable[r] ? OUT_ON : OUT_LOW;  // [R4] [R9] [R11]
            else
                REF_STATE_O[2*r +: 2] <= OUT_OFF;                     // [R4] [R11]
        end

        // divider and delay source: 0 channel, 1 sysref path
        always_ff @(posedge CLOCK_I or negedge NRST_I)
        begin
            if (!NRST_I)
            begin
                REF_DIV_SEL_O[r]   <= 1'b0;
                REF_DELAY_SEL_O[r] <= 1'b0;
                REF_AMP_O[2*r +: 2] <= RST_REF_AMP[2*r +: 2];
            end
            else
            begin
                REF_DIV_SEL_O[r]   <= sysref_fn;                      // [R6]
                REF_DELAY_SEL_O[r] <= sysref_fn;                      // [R7]
                REF_AMP_O[2*r +: 2] <= ref_amp_reg[2*r +: 2];         // [R10]
            end
        end

        // flags for status: switching now, and a wrong code under sysref
        assign ref_live[r] = sysref_fn && (REF_STATE_O[2*r +: 2] == OUT_ON);
    end

    // warn when a sysref output lacks the 500 mV code, a software slip
    always_comb
    begin
        amp_warn = 1'b0;
        for (int i = 0; i < NUM_REF; i++)
        begin
            if (output_function_select[i] && (ref_amp_reg[2*i +: 2] != AMP_SYSREF))
                amp_warn = 1'b1;                                      // [R12]
        end
    end

endmodule
`default_nettype wire

// file: src/sysref_handover.sv
// sysref hand-over state machine owning reference outputs during an event
`timescale 1ns/1ps
`default_nettype none
module sysref_handover
    import clkout_pkg::*;
(
    // clock and reset
    input  wire logic CLOCK_I,
    input  wire logic NRST_I,
    // control link
    sysref_ctl_if.fsm ctl
);

    sysref_state_t state;
    sysref_state_t next_state;

    // ******************************************
    // next state
    // ******************************************
    // stop and done both end the event; a new start is taken only in idle
    always_comb
    begin
        next_state = state;
        case (state)
            SR_IDLE:
            begin
                if (ctl.start && !ctl.stop)
                    next_state = SR_ACTIVE;
            end
            SR_ACTIVE:
            begin
                if (ctl.stop || ctl.done)
                    next_state = SR_IDLE;
            end
            default:
                next_state = SR_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge CLOCK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            state <= SR_IDLE;
        else
            state <= next_state;
    end

    // outputs
    assign ctl.state  = state;
    assign ctl.active = (state == SR_ACTIVE);

endmodule
`default_nettype wire
